// File: ssc_crc_engine.sv
// running CRC register with load and byte fold
`timescale 1ns/1ps
module ssc_crc_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  ssc_crc_if.eng eng
);
  import ssc_pkg::*;

  logic [31:0] crc_q;

  // load beats fold so a reset or software write is never merged with data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crc_q <= CRC_RST; // [RULE_17]
    else if (eng.load)
      crc_q <= eng.load_val;
    else if (eng.fold)
      crc_q <= ssc_fold(crc_q, eng.fold_byte, eng.wide); // [RULE_01] [RULE_02] [RULE_10]
  end

  assign eng.crc = crc_q;
endmodule

// File: ssc_crc_if.sv
// carrier between the CRC control logic and the CRC engine
`timescale 1ns/1ps
interface ssc_crc_if;
  logic load;
  logic [31:0] load_val;
  logic fold;
  logic [7:0] fold_byte;
  logic wide;
  logic [31:0] crc;

  modport eng (input load, input load_val, input fold, input fold_byte, input wide, output crc);
  modport ctl (output load, output load_val, output fold, output fold_byte, output wide, input crc);
endinterface

// File: ssc_crc_top.sv
// CRC generator with APB registers and cpu, dma and flash byte sources
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps

//
// Contract
// RULE_01: narrow mode folds bytes with polynomial 0x1021.
// RULE_02: wide mode folds bytes with polynomial 0x04C11DB7.
// RULE_03: one selected source feeds the generator, whole bytes only.
// RULE_04: width defaults narrow; flash source always uses the wide polynomial.
// RULE_05: control bit 5 picks wide mode; frozen while busy.
// RULE_06: source codes: off, cpu, flash, reserved, dma 0..3, reserved.
// RULE_07: source stays locked until generation completes or module reset.
// RULE_08: reset field 10 clears, 11 sets ones, reads back zero.
// RULE_09: reset field acts one clock after its upper bit is written.
// RULE_10: each byte input write folds; result next cycle; one per cycle.
// RULE_11: software ends a cpu run by writing one to busy.
// RULE_12: selected dma channel bytes fold until that channel completes or aborts.
// RULE_13: flash controller sets range and starts the wide CRC itself; here the run starts when software selects the flash source.
// RULE_14: busy while source in use; cleared by done, abort or software.
// RULE_15: zero flag set if result zero at completion; cleared on new source.
// RULE_16: wide packet with appended little-endian result leaves fixed residue.
// RULE_17: result held in four byte registers, reset to zero.
// RULE_18: wide and idle reads reversed complement; otherwise raw value.
// RULE_19: flash source reads result as zero until busy clears.
// RULE_20: result writes only act while the source is disabled.
// RULE_21: dma bytes fold in transfer order, one byte per beat.
module ssc_crc_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dma channels
  input wire logic [ssc_pkg::DMA_CH-1:0] dma_beat,
  input wire logic [ssc_pkg::DMA_CH*8-1:0] dma_byte,
  input wire logic [ssc_pkg::DMA_CH-1:0] dma_done,
  input wire logic [ssc_pkg::DMA_CH-1:0] dma_abort,
  // flash sweep
  input wire logic nvm_beat,
  input wire logic [7:0] nvm_byte,
  input wire logic nvm_done,
  // status
  output logic crc_busy,
  output logic crc_zero
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] src_q;
  logic wide_q;
  logic busy_q;
  logic zero_q;
  logic chk_q;
  logic [7:0] din_q;
  logic rst_pend_q;
  logic rst_ones_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  ssc_crc_if cif ();

  ssc_crc_engine u_eng (
    .clk(pclk),
    .rst_n(presetn),
    .eng(cif.eng)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic [9:0] idx;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_din;
  logic hit_res;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign idx = paddr[ADDR_W-1:2];

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_din = 1'b0;
    hit_res = 1'b0;
    if (idx == IDX_CTRL)
      hit_ctrl = 1'b1;
    else if (idx == IDX_STATUS)
      hit_stat = 1'b1;
    else if (idx == IDX_BYTE_INPUT)
      hit_din = 1'b1;
    else if (idx >= IDX_RES0 && idx <= IDX_RES3)
      hit_res = 1'b1;
  end

  assign mapped = hit_ctrl | hit_stat | hit_din | hit_res;

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  logic src_io;
  logic src_flash;
  logic src_dma;
  logic [1:0] ch;
  logic new_valid;
  logic sel_evt;
  logic done_evt;
  logic wide_eff;

  assign src_io = src_q == SRC_IO; // [RULE_06]
  assign src_flash = src_q == SRC_FLASH; // [RULE_06]
  assign src_dma = src_q[3:2] == SRC_DMA_TOP; // [RULE_06]
  assign ch = src_q[1:0];
  assign new_valid = pwdata[3:0] == SRC_IO || pwdata[3:0] == SRC_FLASH || pwdata[3:2] == SRC_DMA_TOP;
  // reserved codes are stored but never start a run
  assign sel_evt = wr & hit_ctrl & ~busy_q & new_valid;
  // only the selected channel may end the run, others are ignored
  assign done_evt = busy_q & ((src_io & wr & hit_stat & pwdata[STAT_BUSY]) // [RULE_11]
                   | (src_dma & (dma_done[ch] | dma_abort[ch])) // [RULE_12]
                   | (src_flash & nvm_done)); // [RULE_13]
  assign wide_eff = src_flash | wide_q; // [RULE_04]

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_q <= SRC_RST;
      wide_q <= WIDE_RST;
    end
    else if (wr && hit_ctrl && !busy_q)
    begin
      src_q <= pwdata[3:0]; // [RULE_03] [RULE_07]
      wide_q <= pwdata[CTRL_WIDE]; // [RULE_05]
    end
  end

  // reset field is a command: latched now, applied on the next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_pend_q <= 1'b0;
      rst_ones_q <= 1'b0;
    end
    else
    begin
      rst_pend_q <= wr & hit_ctrl & pwdata[CTRL_RST_HI]; // [RULE_09]
      rst_ones_q <= pwdata[CTRL_RST_LO]; // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else if (sel_evt)
      busy_q <= 1'b1; // [RULE_14]
    else if (done_evt)
      busy_q <= 1'b0; // [RULE_14]
  end

  // zero is judged one cycle after completion so a last byte on the done cycle counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chk_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else
    begin
      chk_q <= done_evt;
      if (chk_q)
        zero_q <= cif.crc == CRC_RST; // [RULE_15]
      else if (sel_evt)
        zero_q <= 1'b0; // [RULE_15]
    end
  end

  // ----------------------------------------------------------------
  // byte input and engine steering
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      din_q <= 8'h00;
    else if (wr && hit_din)
      din_q <= pwdata[7:0];
  end

  logic [31:0] res_wval;

  always_comb
  begin
    res_wval = cif.crc;
    res_wval[paddr[3:2]*8 +: 8] = pwdata[7:0];
  end

  always_comb
  begin
    cif.wide = wide_eff;
    cif.load = 1'b0;
    cif.load_val = res_wval;
    if (rst_pend_q)
    begin
      cif.load = 1'b1; // [RULE_09]
      cif.load_val = rst_ones_q ? CRC_ONES : CRC_RST; // [RULE_08]
    end
    else if (wr && hit_res && src_q == SRC_OFF)
      cif.load = 1'b1; // [RULE_20]
    cif.fold_byte = pwdata[7:0];
    cif.fold = 1'b0;
    if (busy_q && src_io)
      cif.fold = wr & hit_din; // [RULE_10]
    else if (busy_q && src_dma)
    begin
      cif.fold = dma_beat[ch]; // [RULE_12] [RULE_21]
      cif.fold_byte = dma_byte[ch*8 +: 8];
    end
    else if (busy_q && src_flash)
    begin
      cif.fold = nvm_beat; // [RULE_03]
      cif.fold_byte = nvm_byte;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] view;
  logic [31:0] rdval;

  always_comb
  begin
    if (src_flash && busy_q)
      view = CRC_RST; // [RULE_19]
    else if (wide_eff && !busy_q)
      view = ~ssc_bitrev(cif.crc); // [RULE_18] [RULE_16]
    else
      view = cif.crc; // [RULE_18]
    rdval = 32'h0000_0000;
    if (hit_ctrl)
      rdval = {26'h0, wide_q, 1'b0, src_q}; // [RULE_08]
    else if (hit_stat)
      rdval = {30'h0, zero_q, busy_q};
    else if (hit_din)
      rdval = {24'h0, din_q};
    else if (hit_res)
      rdval = {24'h0, view[paddr[3:2]*8 +: 8]}; // [RULE_17]
  end

  // answer is prepared in setup so the access phase ends with zero waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdval;
      pslverr_q <= ~mapped;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = 1'b1;
  assign crc_busy = busy_q;
  assign crc_zero = zero_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rst_zero;
    wr && hit_ctrl && pwdata[7:6] == 2'b10 |=> ##1 cif.crc == CRC_RST;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset to zeros not applied"); // [RULE_09]

  property p_rst_ones;
    wr && hit_ctrl && pwdata[7:6] == 2'b11 |=> ##1 cif.crc == CRC_ONES;
  endproperty
  a_rst_ones: assert property (p_rst_ones) else $error("reset to ones not applied"); // [RULE_08]

  property p_fold;
    busy_q && src_io && wr && hit_din && !rst_pend_q |=> cif.crc == ssc_fold($past(cif.crc), $past(pwdata[7:0]), wide_eff);
  endproperty
  a_fold: assert property (p_fold) else $error("byte input not folded"); // [RULE_10]

  property p_lock;
    busy_q && wr && hit_ctrl |=> $stable(src_q) && $stable(wide_q);
  endproperty
  a_lock: assert property (p_lock) else $error("source changed while busy"); // [RULE_07]

  property p_dma_end;
    busy_q && src_dma && (dma_done[ch] || dma_abort[ch]) |=> !busy_q;
  endproperty
  a_dma_end: assert property (p_dma_end) else $error("busy kept after dma end"); // [RULE_14]

  property p_zero_sel;
    sel_evt && !chk_q |=> !zero_q && busy_q;
  endproperty
  a_zero_sel: assert property (p_zero_sel) else $error("zero flag not cleared on select"); // [RULE_15]

  property p_flash_read;
    setup && !pwrite && hit_res && src_flash && busy_q |=> prdata == 32'h0000_0000;
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("flash result visible while busy"); // [RULE_19]

  property p_res_block;
    wr && hit_res && src_q != SRC_OFF && !rst_pend_q && !cif.fold |=> $stable(cif.crc);
  endproperty
  a_res_block: assert property (p_res_block) else $error("result written while enabled"); // [RULE_20]

  property p_ctrl_read;
    setup && !pwrite && hit_ctrl |=> prdata[7:6] == 2'b00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reset field read nonzero"); // [RULE_08]

  property p_flash_wide;
    src_flash && busy_q && nvm_beat && !rst_pend_q |=> cif.crc == ssc_fold($past(cif.crc), $past(nvm_byte), 1'b1);
  endproperty
  a_flash_wide: assert property (p_flash_wide) else $error("flash run not wide"); // [RULE_04]

  c_io_run: cover property (sel_evt ##[1:20] (busy_q && src_io && done_evt));
  c_dma_run: cover property (busy_q && src_dma && cif.fold ##[1:50] done_evt);
  c_zero: cover property (chk_q ##1 zero_q);
endmodule

// File: ssc_crc_top_bench.sv
// self-checking bench for the CRC generator
`timescale 1ns/1ps
module ssc_crc_top_bench;
  import ssc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_beat, nvm_done, crc_busy, crc_zero;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, dma_byte, c, t;
  logic [3:0] dma_beat, dma_done, dma_abort;
  logic [7:0] nvm_byte, b;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  ssc_crc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_beat(dma_beat), .dma_byte(dma_byte), .dma_done(dma_done), .dma_abort(dma_abort),
    .nvm_beat(nvm_beat), .nvm_byte(nvm_byte), .nvm_done(nvm_done), .crc_busy(crc_busy), .crc_zero(crc_zero));
  ssc_src_model src (.pclk(pclk), .dma_beat(dma_beat), .dma_byte(dma_byte), .dma_done(dma_done),
    .dma_abort(dma_abort), .nvm_beat(nvm_beat), .nvm_byte(nvm_byte), .nvm_done(nvm_done));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // reference and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] fold(logic [31:0] v, logic [7:0] d, logic w);
    for (int i = 0; i < 8; i++)
    begin
      if (w)
        v = (v[31] ^ d[i]) ? {v[30:0], 1'b0} ^ POLY32 : {v[30:0], 1'b0};
      else
        v[15:0] = (v[15] ^ d[7 - i]) ? {v[14:0], 1'b0} ^ POLY16 : {v[14:0], 1'b0};
    end
    return v;
  endfunction
  function automatic logic [31:0] flip(logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = ~v[31 - i];
    return r;
  endfunction
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one idle edge between transfers keeps every signal to one assignment per step
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 8'h00);
  endtask
  task automatic rd_res(input logic [31:0] v);
    for (int k = 0; k < 4; k++)
      rd(IDX_RES0 + 10'(k), {25'h0000000, v[8*k +: 8]});
  endtask
  task automatic flags(input logic eb, input logic ez);
    @(posedge pclk);
    #1;
    cmp("crc_busy", {32'h0, eb}, {32'h0, crc_busy});
    cmp("crc_zero", {32'h0, ez}, {32'h0, crc_zero});
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp("prdata", exp_q.pop_front(), {pslverr, prdata});
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    void'($urandom(25530));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(10'(i), (i == 2 || i == 8) ? 33'h1_0000_0000 : 33'h0);
    flags(1'b0, 1'b0);
    // cpu runs: narrow from zeros, wide from ones, each closed by its own check bytes
    for (int w = 0; w < 2; w++)
    begin
      apb(1'b1, IDX_CTRL, {2'b00, w[0], 1'b0, SRC_IO});
      flags(1'b1, 1'b0);
      apb(1'b1, IDX_CTRL, {1'b1, w[0], ~w[0], 1'b0, SRC_FLASH});
      c = w[0] ? CRC_ONES : CRC_RST;
      rd(IDX_CTRL, {27'h0, w[0], 1'b0, SRC_IO});
      rd_res(c);
      repeat (2 + $urandom % 6)
      begin
        b = 8'($urandom);
        apb(1'b1, IDX_BYTE_INPUT, b);
        c = fold(c, b, w[0]);
      end
      rd_res(c);
      t = w[0] ? flip(c) : {16'h0000, c[7:0], c[15:8]};
      for (int k = 0; k < 2 + 2 * w; k++)
        apb(1'b1, IDX_BYTE_INPUT, t[8*k +: 8]);
      apb(1'b1, IDX_STATUS, 8'h01);
      flags(1'b0, !w[0]);
      rd_res(w[0] ? 32'h2144DF1C : 32'h0000_0000);
    end
    rd(IDX_BYTE_INPUT, {25'h0000000, t[31:24]});
    // dma channels, two completed and two aborted
    for (int ch = 0; ch < 4; ch++)
    begin
      apb(1'b1, IDX_CTRL, {2'b11, ch[0], 1'b0, 2'b01, ch[1:0]});
      c = CRC_ONES;
      flags(1'b1, 1'b0);
      repeat (3 + ch)
      begin
        b = 8'($urandom);
        src.bq.push_back(b);
        c = fold(c, b, ch[0]);
      end
      src.send(ch, ch > 1, ch == 0 ? 0 : 2);
      flags(1'b0, c == 32'h0);
      rd_res(ch[0] ? flip(c) : c);
    end
    // flash sweep with width bit left narrow
    apb(1'b1, IDX_CTRL, {2'b11, 2'b00, SRC_FLASH});
    c = CRC_ONES;
    repeat (8)
    begin
      b = 8'($urandom);
      src.bq.push_back(b);
      c = fold(c, b, 1'b1);
    end
    fork
      src.send(4, 1'b0, 1);
      rd_res(32'h0000_0000);
    join
    flags(1'b0, c == 32'h0);
    rd_res(flip(c));
    for (int s = 3; s < 9; s += 5)
    begin
      apb(1'b1, IDX_CTRL, 8'(s));
      rd(IDX_CTRL, 33'(s));
      flags(1'b0, c == 32'h0);
    end
    // result writes: taken while disabled, ignored while a run holds the source
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_RES0, 8'hA5);
    rd(IDX_RES0, 33'h0A5);
    apb(1'b1, IDX_CTRL, {4'h0, SRC_IO});
    apb(1'b1, IDX_RES0, 8'h5A);
    rd(IDX_RES0, 33'h0A5);
    // reset in mid-run frees the locked source and clears the result
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CTRL, 33'h0);
    flags(1'b0, 1'b0);
    rd_res(32'h0000_0000);
    apb(1'b1, IDX_STATUS, 8'h01);
    wrap_up();
  end
endmodule

// File: ssc_pkg.sv
// shared constants, register map and CRC fold functions for the CRC generator
package ssc_pkg;

  // ----------------------------------------------------------------
  // register map (printed index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL = 10'h000;
  localparam logic [9:0] IDX_STATUS = 10'h001;
  localparam logic [9:0] IDX_BYTE_INPUT = 10'h003;
  localparam logic [9:0] IDX_RES0 = 10'h004;
  localparam logic [9:0] IDX_RES3 = 10'h007;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RST_HI = 7;
  localparam int CTRL_RST_LO = 6;
  localparam int CTRL_WIDE = 5;
  localparam int STAT_ZERO = 1;
  localparam int STAT_BUSY = 0;

  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_IO = 4'h1;
  localparam logic [3:0] SRC_FLASH = 4'h2;
  localparam logic [1:0] SRC_DMA_TOP = 2'h1;
  localparam int DMA_CH = 4;

  // ----------------------------------------------------------------
  // reset values and polynomials
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_RST = 4'h0;
  localparam logic WIDE_RST = 1'b0;
  localparam logic [31:0] CRC_RST = 32'h0000_0000;
  localparam logic [31:0] CRC_ONES = 32'hFFFF_FFFF;
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [31:0] POLY32 = 32'h04C1_1DB7;

  // one byte into the running value; narrow mode is msb first, wide mode lsb first
  function automatic logic [31:0] ssc_fold(input logic [31:0] c, input logic [7:0] b, input logic wide);
    logic [31:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (wide)
      begin
        fb = r[31] ^ b[i];
        r = {r[30:0], 1'b0} ^ (fb ? POLY32 : 32'h0000_0000);
      end
      else
      begin
        fb = r[15] ^ b[7 - i];
        r[15:0] = {r[14:0], 1'b0} ^ (fb ? POLY16 : 16'h0000);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ssc_bitrev(input logic [31:0] c);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      r[i] = c[31 - i];
    end
    return r;
  endfunction

endpackage

// File: ssc_src_model.sv
// dma channel and flash sweep model feeding the CRC generator
`timescale 1ns/1ps
module ssc_src_model (
  // clock
  input wire logic pclk,
  // dma channels
  output logic [3:0] dma_beat,
  output logic [31:0] dma_byte,
  output logic [3:0] dma_done,
  output logic [3:0] dma_abort,
  // flash sweep
  output logic nvm_beat,
  output logic [7:0] nvm_byte,
  output logic nvm_done
);
  logic [7:0] bq[$];
  initial
  begin
    dma_beat = 4'h0;
    dma_byte = 32'h0000_0000;
    dma_done = 4'h0;
    dma_abort = 4'h0;
    nvm_beat = 1'b0;
    nvm_byte = 8'h00;
    nvm_done = 1'b0;
  end
  // ch 4 means the flash sweep; idle byte lanes toggle so a stale byte never looks valid
  task automatic send(input int ch, input logic abort, input int gap);
    logic [3:0] one;
    one = 4'h1 << ch;
    while (bq.size() > 0)
    begin
      @(posedge pclk);
      dma_beat <= one;
      nvm_beat <= (ch == 4);
      dma_byte <= {4{bq[0]}};
      nvm_byte <= bq.pop_front();
      repeat (gap)
      begin
        @(posedge pclk);
        dma_beat <= 4'h1 << ((ch + 1) % 4);
        nvm_beat <= 1'b0;
        dma_byte <= ~dma_byte;
        nvm_byte <= ~nvm_byte;
      end
    end
    @(posedge pclk);
    dma_beat <= 4'h0;
    nvm_beat <= 1'b0;
    dma_done <= abort ? 4'h0 : one;
    dma_abort <= abort ? one : 4'h0;
    nvm_done <= (ch == 4);
    dma_byte <= ~dma_byte;
    nvm_byte <= ~nvm_byte;
    @(posedge pclk);
    dma_done <= 4'h0;
    dma_abort <= 4'h0;
    nvm_done <= 1'b0;
  endtask
endmodule
